// ---- core/tdb_pkg.sv ----
// shared constants and types for the timer dma burst port
package tdb_pkg;
   localparam int unsigned ADDR_W         = 8;
   localparam int unsigned DATA_W         = 16;
   localparam int unsigned FIELD_W        = 5;
   localparam int unsigned BYTE_W         = 8;

   localparam logic [7:0]  OFS_CTRL_ONE   = 8'h00;
   localparam logic [7:0]  OFS_BURST_CTRL = 8'h48;
   localparam logic [7:0]  OFS_BURST_DATA = 8'h4C;

   localparam int unsigned BASE_LSB       = 0;
   localparam int unsigned LEN_LSB        = 8;

   localparam logic [15:0] RST_BURST_CTRL = 16'h0000;
   localparam logic [15:0] RST_BURST_DATA = 16'h0000;
   localparam logic [15:0] CTRL_RW_MASK   = 16'h1F1F;

   localparam int unsigned TIMER_CLK_MHZ  = 125;
   localparam int unsigned REG_STRIDE     = 4;

   typedef enum logic [1:0] {
      TDB_TGT_NONE,
      TDB_TGT_CTRL,
      TDB_TGT_WINDOW,
      TDB_TGT_TIMER
   } tdb_target_e;

   typedef struct packed {
      logic                  wr;
      logic                  rd;
      logic [ADDR_W-1:0]     addr;
      logic [DATA_W-1:0]     wdata;
   } tdb_tmr_req_s;

   typedef struct packed {
      logic [FIELD_W-1:0]    base;
      logic [FIELD_W-1:0]    len;
   } tdb_cfg_s;
endpackage

// ---- core/tdb_index.sv ----
// transfer index counter for one burst
`timescale 1ns/100ps
module tdb_index
   import tdb_pkg::*;
(
   input  wire logic               core_clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               ce_i,
   input  wire logic               clear_i,
   input  wire logic               advance_i,
   input  wire logic [FIELD_W-1:0] len_i,
   output logic      [FIELD_W-1:0] idx_o,
   output logic                    last_o
);
   logic [FIELD_W-1:0] idx_r;
   logic [FIELD_W-1:0] idx_nxt;

   assign last_o = (idx_r >= len_i);
   assign idx_o  = idx_r;

   always_comb begin
      idx_nxt = idx_r;
      if (clear_i) begin
         idx_nxt = '0;
      end else if (advance_i) begin
         // wrap after the last transfer so the next burst restarts
         if (last_o) begin
            idx_nxt = '0;
         end else begin
            idx_nxt = idx_r + FIELD_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx_r <= '0;
      end else if (ce_i) begin
         idx_r <= idx_nxt;
      end
   end
endmodule

// ---- core/tdb_burst.sv ----
// burst access port redirecting a data window onto the timer registers
`timescale 1ns/100ps
// Operation
// - base field picks first register offset
// - burst runs length field plus one transfers
// - target is control one plus four times sum
// - index advances itself after each window access
// - byte mode: high byte first, then low
// - control and data registers reset to zero
module tdb_burst
   import tdb_pkg::*;
(
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  ce_i,
   input  wire logic [ADDR_W-1:0]     addr_i,
   input  wire logic [DATA_W-1:0]     wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [DATA_W-1:0]     rdata_o,
   input  wire logic                  dma_byte_mode_i,
   output tdb_tmr_req_s               tmr_req_o,
   input  wire logic [DATA_W-1:0]     tmr_rdata_i,
   output logic      [FIELD_W-1:0]    burst_index_o,
   output logic                       burst_active_o,
   output logic                       burst_done_o,
   output logic      [DATA_W-1:0]     burst_data_o
);
   logic [DATA_W-1:0]  burst_ctrl_r;
   logic [DATA_W-1:0]  burst_data_r;
   logic [DATA_W-1:0]  rdata_r;
   logic               done_r;
   tdb_cfg_s           cfg;
   tdb_target_e        target;
   logic [FIELD_W-1:0] idx;
   logic               idx_last;
   logic               win_access;
   logic               ctrl_write;
   logic [FIELD_W:0]   word_ofs;
   logic [ADDR_W-1:0]  redirect_addr;
   logic               high_lane;
   logic [DATA_W-1:0]  win_wdata;
   logic [DATA_W-1:0]  win_rdata;

   function automatic tdb_target_e decode(input logic [ADDR_W-1:0] a, input logic strobe);
      tdb_target_e t;
      t = TDB_TGT_NONE;
      if (strobe) begin
         case (a)
            OFS_BURST_CTRL: t = TDB_TGT_CTRL;
            OFS_BURST_DATA: t = TDB_TGT_WINDOW;
            default:        t = TDB_TGT_TIMER;
         endcase
      end
      return t;
   endfunction

   assign target     = decode(addr_i, wr_i | rd_i);
   assign win_access = ce_i && (target == TDB_TGT_WINDOW);
   assign ctrl_write = ce_i && wr_i && (target == TDB_TGT_CTRL);

   assign cfg.base   = burst_ctrl_r[BASE_LSB +: FIELD_W];
   assign cfg.len    = burst_ctrl_r[LEN_LSB +: FIELD_W];

   // word offset from control one, then scaled to a byte address
   assign word_ofs      = {1'b0, cfg.base} + {1'b0, idx};
   assign redirect_addr = OFS_CTRL_ONE + ADDR_W'(word_ofs * REG_STRIDE);

   // even index carries the high byte, odd index the low byte
   assign high_lane = ~idx[0];

   // write lane: the selected byte lands zero-extended in the target
   always_comb begin
      win_wdata = wdata_i;
      if (dma_byte_mode_i) begin
         if (high_lane) begin
            win_wdata = {{BYTE_W{1'b0}}, wdata_i[DATA_W-1 -: BYTE_W]};
         end else begin
            win_wdata = {{BYTE_W{1'b0}}, wdata_i[BYTE_W-1:0]};
         end
      end
   end

   // read lane: target low byte returns in the lane of this index
   always_comb begin
      win_rdata = tmr_rdata_i;
      if (dma_byte_mode_i) begin
         if (high_lane) begin
            win_rdata = {tmr_rdata_i[BYTE_W-1:0], {BYTE_W{1'b0}}};
         end else begin
            win_rdata = {{BYTE_W{1'b0}}, tmr_rdata_i[BYTE_W-1:0]};
         end
      end
   end

   tdb_index u_index (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .ce_i       (ce_i),
      .clear_i    (ctrl_write),
      .advance_i  (win_access),
      .len_i      (cfg.len),
      .idx_o      (idx),
      .last_o     (idx_last)
   );

   // timer-side request, combinational beside the incoming strobe
   always_comb begin
      tmr_req_o = '0;
      if (ce_i) begin
         case (target)
            TDB_TGT_WINDOW: begin
               tmr_req_o.wr    = wr_i;
               tmr_req_o.rd    = rd_i;
               tmr_req_o.addr  = redirect_addr;
               tmr_req_o.wdata = win_wdata;
            end
            TDB_TGT_TIMER: begin
               tmr_req_o.wr    = wr_i;
               tmr_req_o.rd    = rd_i;
               tmr_req_o.addr  = addr_i;
               tmr_req_o.wdata = wdata_i;
            end
            default: begin
               tmr_req_o = '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         burst_ctrl_r <= RST_BURST_CTRL;
      end else if (ctrl_write) begin
         burst_ctrl_r <= wdata_i & CTRL_RW_MASK;
      end
   end

   // last value moved through the window
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         burst_data_r <= RST_BURST_DATA;
      end else if (win_access) begin
         burst_data_r <= wr_i ? win_wdata : win_rdata;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= '0;
      end else if (ce_i) begin
         rdata_r <= '0;
         if (rd_i) begin
            case (target)
               TDB_TGT_CTRL:   rdata_r <= burst_ctrl_r;
               TDB_TGT_WINDOW: rdata_r <= win_rdata;
               TDB_TGT_TIMER:  rdata_r <= tmr_rdata_i;
               default:        rdata_r <= '0;
            endcase
         end
      end
   end

   // one-cycle pulse after the final transfer of a burst
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_r <= 1'b0;
      end else if (ce_i) begin
         done_r <= win_access && idx_last;
      end
   end

   assign rdata_o        = rdata_r;
   assign burst_index_o  = idx;
   assign burst_active_o = (idx != '0);
   assign burst_done_o   = done_r;
   assign burst_data_o   = burst_data_r;
endmodule

// ---- tb/tdb_burst_props.sv ----
// assertions on the burst port
`timescale 1ns/100ps
module tdb_burst_props
   import tdb_pkg::*;
(
   input wire logic               core_clk_i,
   input wire logic               rst_n_i,
   input wire logic               ce_i,
   input wire logic [ADDR_W-1:0]  addr_i,
   input wire logic [DATA_W-1:0]  wdata_i,
   input wire logic               wr_i,
   input wire logic               rd_i,
   input wire logic [DATA_W-1:0]  rdata_o,
   input wire logic               dma_byte_mode_i,
   input tdb_tmr_req_s            tmr_req_o,
   input wire logic [FIELD_W-1:0] burst_index_o,
   input wire logic               burst_done_o
);
   logic [4:0] base_r;
   logic [4:0] len_r;
   logic       w;
   assign w = ce_i && (wr_i || rd_i) && addr_i == OFS_BURST_DATA;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         base_r <= 5'h00;
         len_r <= 5'h00;
      end else if (ce_i && wr_i && addr_i == OFS_BURST_CTRL) begin
         base_r <= wdata_i[4:0];
         len_r <= wdata_i[12:8];
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_target_addr: assert property (w |->
      tmr_req_o.addr == 8'(({3'h0, base_r} + burst_index_o) << 2)) else $error("bad target");
   a_index_step: assert property (w && burst_index_o != len_r |=>
      burst_index_o == $past(burst_index_o) + 5'h01) else $error("bad step");
   a_burst_wrap: assert property (w && burst_index_o == len_r |=>
      burst_done_o && burst_index_o == 5'h00) else $error("bad wrap");
   a_byte_high: assert property (w && wr_i && dma_byte_mode_i && !burst_index_o[0] |->
      tmr_req_o.wdata == {8'h00, wdata_i[15:8]}) else $error("bad msb");
   a_word_pass: assert property (w && wr_i && !dma_byte_mode_i |->
      tmr_req_o.wr && tmr_req_o.wdata == wdata_i) else $error("bad word");
   a_reset_clear: assert property ($rose(rst_n_i) |->
      burst_index_o == 5'h00 && rdata_o == 16'h0000) else $error("bad reset");
endmodule
bind tdb_burst tdb_burst_props u_tdb_burst_props (.core_clk_i, .rst_n_i, .ce_i, .addr_i, .wdata_i,
   .wr_i, .rd_i, .rdata_o, .dma_byte_mode_i, .tmr_req_o, .burst_index_o, .burst_done_o);

// ---- tb/tdb_tmr_model.sv ----
// timer register file behind the redirect port
`timescale 1ns/100ps
module tdb_tmr_model
   import tdb_pkg::*;
(
   input wire logic          core_clk_i,
   input tdb_tmr_req_s       req_i,
   output logic [DATA_W-1:0] rdata_o
);
   logic [DATA_W-1:0] mem [64];
   initial foreach (mem[i]) mem[i] = 16'h1000 + 16'(i);
   always @(posedge core_clk_i) if (req_i.wr) mem[req_i.addr[7:2]] <= req_i.wdata;
   // idle read bus shows inverted data
   assign rdata_o = req_i.rd ? mem[req_i.addr[7:2]] : ~mem[req_i.addr[7:2]];
endmodule

// ---- tb/tdb_burst_tb_top.sv ----
// self-checking bench for the burst port
`timescale 1ns/100ps
module tdb_burst_tb_top;
   import tdb_pkg::*;
   logic         core_clk_i = 1'h0, rst_n_i = 1'h0, ce_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, bm = 1'h0;
   logic [7:0]   addr_i = 8'h00;
   logic [15:0]  wdata_i = 16'h0000, rdata_o, trd, q;
   tdb_tmr_req_s req;
   logic [4:0]   idx;
   logic         done;
   logic         act;
   logic [15:0]  bdat;
   int           num_errors = 0, n_checks = 0, cyc = 0;
   always #4 core_clk_i = ~core_clk_i;
   tdb_burst u_tdb_burst (.core_clk_i, .rst_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .dma_byte_mode_i(bm), .tmr_req_o(req), .tmr_rdata_i(trd), .burst_index_o(idx),
      .burst_active_o(act), .burst_done_o(done), .burst_data_o(bdat));
   tdb_tmr_model u_tdb_tmr_model (.core_clk_i, .req_i(req), .rdata_o(trd));
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      wr_i <= 1'h0;
      rd_i <= 1'h0;
      #1 q = rdata_o;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_reset;
      bus(1'h0, OFS_BURST_CTRL, 16'h0000);
      chk("ctrl", RST_BURST_CTRL, q);
      @(posedge core_clk_i) ce_i <= 1'h0;
      bus(1'h1, OFS_BURST_CTRL, 16'hFFFF);
      @(posedge core_clk_i) ce_i <= 1'h1;
      bus(1'h0, OFS_BURST_CTRL, 16'h0000);
      chk("frozen", RST_BURST_CTRL, q);
      bus(1'h1, OFS_BURST_CTRL, 16'hFFFF);
      bus(1'h0, OFS_BURST_CTRL, 16'h0000);
      chk("fields", 16'h1F1F, q);
   endtask
   task automatic t_word;
      bus(1'h1, OFS_BURST_CTRL, 16'h0201);
      for (int i = 0; i < 3; i++) begin
         bus(1'h1, OFS_BURST_DATA, 16'hC000 + 16'(i));
         chk("done", {15'h0000, i == 2}, {15'h0000, done});
         chk("active", {15'h0000, i != 2}, {15'h0000, act});
         chk("wdata", 16'hC000 + 16'(i), bdat);
      end
      for (int i = 0; i < 3; i++) chk("word", 16'hC000 + 16'(i), u_tdb_tmr_model.mem[1 + i]);
   endtask
   task automatic t_read;
      bus(1'h1, OFS_BURST_CTRL, 16'h1104);
      for (int i = 0; i < 18; i++) begin
         bus(1'h0, OFS_BURST_DATA, 16'h0000);
         chk("read", 16'h1004 + 16'(i), q);
      end
      chk("done", 16'h0001, {15'h0000, done});
   endtask
   task automatic t_byte;
      @(posedge core_clk_i) bm <= 1'h1;
      bus(1'h1, OFS_BURST_CTRL, 16'h0102);
      bus(1'h1, OFS_BURST_DATA, 16'hAB12);
      bus(1'h1, OFS_BURST_DATA, 16'h34CD);
      chk("msb", 16'h00AB, u_tdb_tmr_model.mem[2]);
      chk("lsb", 16'h00CD, u_tdb_tmr_model.mem[3]);
      bus(1'h0, OFS_BURST_DATA, 16'h0000);
      chk("rmsb", 16'hAB00, q);
      bus(1'h0, OFS_BURST_DATA, 16'h0000);
      chk("rlsb", 16'h00CD, q);
      chk("bdata", 16'h00CD, bdat);
   endtask
   task automatic t_mid_reset;
      @(posedge core_clk_i) bm <= 1'h0;
      bus(1'h1, OFS_BURST_CTRL, 16'h0302);
      bus(1'h1, OFS_BURST_DATA, 16'h5A5A);
      chk("active", 16'h0001, {15'h0000, act});
      chk("data", 16'h5A5A, bdat);
      @(posedge core_clk_i) rst_n_i <= 1'h0;
      @(posedge core_clk_i) rst_n_i <= 1'h1;
      bus(1'h0, OFS_BURST_CTRL, 16'h0000);
      chk("rctrl", RST_BURST_CTRL, q);
      chk("ridx", 16'h0000, {11'h000, idx});
      chk("ractive", 16'h0000, {15'h0000, act});
      chk("rdata", RST_BURST_DATA, bdat);
   endtask
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 1000) begin
         num_errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (5) @(posedge core_clk_i);
      rst_n_i <= 1'h1;
      t_reset();
      t_word();
      t_read();
      t_byte();
      t_mid_reset();
      end_of_test();
   end
endmodule
